// File: cmd_interp_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cmd_interp_sva
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        cal_reload,
  input wire logic        active_protocol
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd_taken;
    arvalid && arready;
  endsequence
  sequence s_rd_unmapped;
    s_rd_taken ##0 (araddr[7:2] > 6'h04);
  endsequence
  sequence s_wr_both;
    awvalid && awready && wvalid && wready;
  endsequence
  a_read_answer: assert property (s_rd_taken |=> rvalid)
    else $error("read not answered in the next cycle");
  a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped or changed before rready");
  a_read_block: assert property (rvalid |-> !arready)
    else $error("read address accepted while answer pending");
  a_unmapped_read: assert property (s_rd_unmapped |=> rresp == 2'h2 && rdata == 32'h0)
    else $error("unmapped read not answered with slave error");
  a_write_answer: assert property (s_wr_both |-> ##[1:2] bvalid)
    else $error("write response late");
  a_write_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before bready");
  a_write_block: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  a_cal_pulse: assert property (cal_reload |=> !cal_reload)
    else $error("calibration reload pulse longer than one cycle");
  a_proto_frozen: assert property ($past(aresetn) |-> $stable(active_protocol))
    else $error("running protocol changed without reset");
endmodule
bind protocol_watchdog_cmd_interp cmd_interp_sva cmd_interp_sva_inst
(
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
  .rready(rready), .cal_reload(cal_reload), .active_protocol(active_protocol)
);
`default_nettype wire

// File: cmd_map.svh
`ifndef CMD_MAP_SVH
`define CMD_MAP_SVH
`define OFF_RX       8'h00
`define OFF_TX       8'h04
`define OFF_CFG      8'h08
`define OFF_NV       8'h0C
`define OFF_STAT     8'h10
`define BUF_DEPTH    10
`define Q_DEPTH      8
`define CH_DOLLAR    8'h24
`define CH_TILDE     8'h7E
`define CH_STAR      8'h2A
`define CH_CR        8'h0D
`define CH_BANG      8'h21
`define CH_QUEST     8'h3F
`define CH_P         8'h50
`define CH_S         8'h53
`define CH_D0        8'h30
`define CH_D1        8'h31
`define CH_D3        8'h33
`define RST_ADDR     8'h01
`define RST_PROTO    1'b0
`define RST_CAP      1'b1
`define RST_TMO      8'h64
`define WD_TMO_BIT   2
`define WD_EN_BIT    7
`define CLK_NS       10
`define TENTH_NS     100000000
`define TENTH_CYCLES (`TENTH_NS / `CLK_NS)
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

// File: cmd_pkg.sv
`include "cmd_map.svh"
package cmd_pkg;
  typedef logic [`BUF_DEPTH-1:0][7:0] frame_t;

  typedef struct packed {
    logic       aw_got;
    logic [7:0] aw_addr;
    logic       w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] sw_sync;
    frame_t     fbuf;
    logic [3:0] flen;
    logic       ovf;
    logic [7:0] my_addr;
    logic       modbus_cap;
    logic       chk_en;
    logic       stored_proto;
    logic       active_proto;
    logic       wd_flag;
    logic       wd_en;
    logic [7:0] wd_tmo;
    logic [23:0] tick;
    logic [7:0] units;
    logic       cal_pulse;
    logic [7:0] cal_cnt;
  } main_s;

  typedef struct packed {
    logic [`Q_DEPTH-1:0][7:0] q;
    logic [3:0] cnt;
    logic [2:0] idx;
  } resp_s;

  function automatic logic [7:0] nib2hex(input logic [3:0] v);
    return (v < 4'hA) ? {4'h3, v} : 8'(8'h37 + {4'h0, v});
  endfunction

  function automatic logic [4:0] hex2nib(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39)
      return {1'b1, c[3:0]};
    if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
      return {1'b1, 4'(c[3:0] + 4'h9)};
    return 5'h00;
  endfunction
endpackage

// File: host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model
(
  input  wire logic        aclk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // Ready is read 1 ns after the edge; inputs only move at edges, so it equals the sampled value
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic da = 1'h0;
    logic dw = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(da && dw))
    begin
      #1;
      if (awready && !da) da = 1'h1;
      if (wready && !dw) dw = 1'h1;
      @(posedge aclk);
      if (da) awvalid <= 1'h0;
      if (dw) wvalid <= 1'h0;
    end
    #1;
    while (!bvalid) @(posedge aclk) #1;
    resp = bresp;
    @(posedge aclk);
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    #1;
    while (!arready) @(posedge aclk) #1;
    @(posedge aclk);
    arvalid <= 1'h0;
    #1;
    while (!rvalid) @(posedge aclk) #1;
    d = rdata;
    resp = rresp;
    @(posedge aclk);
    rready <= 1'h0;
  endtask
  // Sends one frame and drains the whole answer; silence leaves got at zero
  task automatic frame(input string s, output logic [63:0] got);
    logic [31:0] d;
    logic [1:0]  r;
    got = 64'h0;
    foreach (s[i]) wr(8'h00, {24'h0, s[i]}, r);
    wr(8'h00, 32'h0D, r);
    for (int k = 0; k < 8; k++)
    begin
      rd(8'h04, d, r);
      if (d[8] !== 1'h1) break;
      got = {got[55:0], d[7:0]};
    end
  endtask
endmodule
`default_nettype wire

// File: protocol_watchdog_cmd_interp.sv
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "cmd_map.svh"
module protocol_watchdog_cmd_interp
  import cmd_pkg::*;
#(
  parameter int TENTH_CYCLES = `TENTH_CYCLES
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        init_sw_pos,
  output logic             cal_reload,
  output logic             active_protocol
);
  main_s r;
  main_s n;
  resp_if rif ();

  resp_tx u_tx (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rif     (rif)
  );

  assign awready         = !r.aw_got && !r.bvalid;
  assign wready          = !r.w_got && !r.bvalid;
  assign arready         = !r.rvalid;
  assign bvalid          = r.bvalid;
  assign bresp           = r.bresp;
  assign rvalid          = r.rvalid;
  assign rdata           = r.rdata;
  assign rresp           = r.rresp;
  assign cal_reload      = r.cal_pulse;
  assign active_protocol = r.active_proto;
  assign rif.chk_en      = r.chk_en;

  always_comb
  begin
    logic        rx_ok;
    logic [7:0]  c;
    logic [7:0]  wa;
    logic [7:0]  sum;
    logic [3:0]  m;
    logic        good;
    logic        okr;
    logic [1:0]  dl;
    logic [15:0] dat;
    logic [4:0]  ah;
    logic [4:0]  al;
    logic [4:0]  th;
    logic [4:0]  tl;
    logic        alive;
    logic        kick;
    logic        clr;
    logic [7:0]  stat;
    rx_ok    = 1'b0;
    c        = r.wdata[7:0];
    wa       = {r.aw_addr[7:2], 2'b00};
    sum      = 8'h00;
    m        = r.flen;
    good     = 1'b1;
    okr      = 1'b0;
    dl       = 2'h0;
    dat      = 16'h0000;
    ah       = hex2nib(r.fbuf[1]);
    al       = hex2nib(r.fbuf[2]);
    th       = hex2nib(r.fbuf[5]);
    tl       = hex2nib(r.fbuf[6]);
    alive    = 1'b0;
    kick     = 1'b0;
    clr      = 1'b0;
    stat     = 8'h00;
    stat[`WD_TMO_BIT] = r.wd_flag;
    stat[`WD_EN_BIT]  = r.wd_en;
    n           = r;
    n.cal_pulse = 1'b0;
    n.sw_sync   = {r.sw_sync[0], init_sw_pos};
    rif.load    = 1'b0;
    rif.msg     = '0;
    rif.len     = 3'h0;
    rif.pop     = 1'b0;

    if (awvalid && awready)
    begin
      n.aw_got  = 1'b1;
      n.aw_addr = awaddr;
    end
    if (wvalid && wready)
    begin
      n.w_got = 1'b1;
      n.wdata = wdata;
      n.wstrb = wstrb;
    end
    if (r.bvalid && bready)
      n.bvalid = 1'b0;
    if (r.aw_got && r.w_got && !r.bvalid)
    begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = `RESP_OKAY;
      if (wa == `OFF_RX)
        // Characters written while an answer is still queued are dropped
        rx_ok = r.wstrb[0] && !rif.busy;
      else if (wa == `OFF_CFG)
      begin
        if (r.wstrb[0])
          n.my_addr = r.wdata[7:0];
        if (r.wstrb[1])
        begin
          n.modbus_cap = r.wdata[8];
          n.chk_en     = r.wdata[9];
        end
      end
      else if (wa == `OFF_NV)
      begin
        // Restore path for the persistent copy; a write here can only set the flag, never clear it
        if (r.wstrb[0])
        begin
          n.stored_proto = r.wdata[0];
          n.wd_flag      = r.wd_flag | r.wdata[`WD_TMO_BIT];
          n.wd_en        = r.wdata[`WD_EN_BIT];
          kick           = r.wdata[`WD_EN_BIT];
        end
        if (r.wstrb[1])
          n.wd_tmo = r.wdata[15:8];
      end
      else if (wa != `OFF_TX && wa != `OFF_STAT)
        n.bresp = `RESP_SLVERR;
    end

    if (r.rvalid && rready)
      n.rvalid = 1'b0;
    if (arvalid && arready)
    begin
      n.rvalid = 1'b1;
      n.rresp  = `RESP_OKAY;
      n.rdata  = 32'h0;
      unique case ({araddr[7:2], 2'b00})
        `OFF_TX:
        begin
          n.rdata = {23'h0, rif.busy, rif.ch};
          rif.pop = rif.busy;
        end
        `OFF_CFG:  n.rdata = {22'h0, r.chk_en, r.modbus_cap, r.my_addr};
        `OFF_NV:   n.rdata = {16'h0, r.wd_tmo, stat | {7'h0, r.stored_proto}};
        `OFF_STAT: n.rdata = {16'h0, r.cal_cnt, 5'h0, r.sw_sync[1], r.active_proto, rif.busy};
        default:   n.rresp = `RESP_SLVERR;
      endcase
    end

    if (rx_ok)
    begin
      if (c == `CH_CR)
      begin
        n.flen = 4'h0;
        n.ovf  = 1'b0;
        if (r.flen == 4'h0 || r.ovf)
          good = 1'b0;
        if (r.chk_en)
        begin
          m = 4'(r.flen - 4'h2);
          th = hex2nib(r.fbuf[4'(r.flen - 4'h2)]);
          tl = hex2nib(r.fbuf[4'(r.flen - 4'h1)]);
          for (int i = 0; i < `BUF_DEPTH; i++)
          begin
            if (i < int'(r.flen) - 2)
              sum = 8'(sum + r.fbuf[i]);
          end
          if (r.flen < 4'h3 || !th[4] || !tl[4] || {th[3:0], tl[3:0]} != sum)
            good = 1'b0;
          th = hex2nib(r.fbuf[5]);
          tl = hex2nib(r.fbuf[6]);
        end
        if (good && m == 4'h3 && r.fbuf[0] == `CH_TILDE && r.fbuf[1] == `CH_STAR
            && r.fbuf[2] == `CH_STAR)
          alive = 1'b1;
        else if (good && m >= 4'h4 && ah[4] && al[4]
                 && {ah[3:0], al[3:0]} == r.my_addr)
        begin
          if (r.fbuf[0] == `CH_DOLLAR && r.fbuf[3] == `CH_P && m == 4'h4)
          begin
            okr = 1'b1;
            dat = {nib2hex({3'h0, r.modbus_cap}),
                   nib2hex({3'h0, r.stored_proto})};
            dl  = 2'h2;
          end
          else if (r.fbuf[0] == `CH_DOLLAR && r.fbuf[3] == `CH_P && m == 4'h5
                   && (r.fbuf[4] == `CH_D0 || r.fbuf[4] == `CH_D1))
          begin
            okr = r.sw_sync[1];
            if (r.sw_sync[1])
              n.stored_proto = r.fbuf[4][0];
          end
          else if (r.fbuf[0] == `CH_DOLLAR && r.fbuf[3] == `CH_S && m == 4'h5
                   && r.fbuf[4] == `CH_D1)
          begin
            okr         = 1'b1;
            n.cal_pulse = 1'b1;
            n.cal_cnt   = 8'(r.cal_cnt + 8'h1);
          end
          else if (r.fbuf[0] == `CH_TILDE && r.fbuf[3] == `CH_D0 && m == 4'h4)
          begin
            okr = 1'b1;
            dat = {nib2hex(stat[7:4]), nib2hex(stat[3:0])};
            dl  = 2'h2;
          end
          else if (r.fbuf[0] == `CH_TILDE && r.fbuf[3] == `CH_D1 && m == 4'h4)
          begin
            okr = 1'b1;
            clr = 1'b1;
          end
          else if (r.fbuf[0] == `CH_TILDE && r.fbuf[3] == `CH_D3 && m == 4'h7
                   && (r.fbuf[4] == `CH_D0 || r.fbuf[4] == `CH_D1) && th[4] && tl[4])
          begin
            okr      = 1'b1;
            n.wd_en  = r.fbuf[4][0];
            n.wd_tmo = {th[3:0], tl[3:0]};
            kick     = r.fbuf[4][0];
          end
          rif.load   = 1'b1;
          rif.msg[0] = okr ? `CH_BANG : `CH_QUEST;
          rif.msg[1] = nib2hex(r.my_addr[7:4]);
          rif.msg[2] = nib2hex(r.my_addr[3:0]);
          rif.msg[3] = dat[15:8];
          rif.msg[4] = dat[7:0];
          rif.len    = 3'(3'h3 + {1'b0, dl});
        end
      end
      else if (c == `CH_DOLLAR || c == `CH_TILDE)
      begin
        // A delimiter always restarts the frame, resyncing after line noise
        n.fbuf[0] = c;
        n.flen    = 4'h1;
        n.ovf     = 1'b0;
      end
      else if (r.flen != 4'h0)
      begin
        if (r.flen == 4'(`BUF_DEPTH))
          n.ovf = 1'b1;
        else
        begin
          n.fbuf[r.flen] = c;
          n.flen         = 4'(r.flen + 4'h1);
        end
      end
    end

    if (clr)
      n.wd_flag = 1'b0;
    if (kick || (alive && r.wd_en))
    begin
      n.tick  = 24'(TENTH_CYCLES - 1);
      n.units = kick ? n.wd_tmo : r.wd_tmo;
    end
    else if (r.wd_en)
    begin
      if (r.tick != 24'h0)
        n.tick = 24'(r.tick - 24'h1);
      else
      begin
        n.tick = 24'(TENTH_CYCLES - 1);
        // A zero count is handled as the shortest period
        if (r.units <= 8'h01)
        begin
          n.wd_flag = 1'b1;
          n.wd_en   = 1'b0;
        end
        else
          n.units = 8'(r.units - 8'h1);
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r              <= '0;
      r.my_addr      <= `RST_ADDR;
      r.modbus_cap   <= `RST_CAP;
      r.stored_proto <= `RST_PROTO;
      r.active_proto <= `RST_PROTO;
      r.wd_tmo       <= `RST_TMO;
    end
    else
      r <= n;
  end
endmodule
`default_nettype wire

// File: resp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface resp_if;
  logic            load;
  logic [4:0][7:0] msg;
  logic [2:0]      len;
  logic            chk_en;
  logic            pop;
  logic [7:0]      ch;
  logic            busy;
  modport parser (output load, msg, len, chk_en, pop, input ch, busy);
  modport sender (input load, msg, len, chk_en, pop, output ch, busy);
endinterface
`default_nettype wire

// File: resp_tx.sv
`timescale 1ns/1ps
`default_nettype none
module resp_tx
  import cmd_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  resp_if.sender    rif
);
  resp_s r;
  resp_s n;

  assign rif.ch   = r.q[r.idx];
  assign rif.busy = (r.cnt != 4'h0);

  always_comb
  begin
    logic [7:0] sum;
    logic [3:0] k;
    sum = 8'h00;
    k   = 4'h0;
    n   = r;
    if (rif.load && r.cnt == 4'h0)
    begin
      for (int i = 0; i < 5; i++)
      begin
        if (i < int'(rif.len))
        begin
          n.q[i] = rif.msg[i];
          sum    = 8'(sum + rif.msg[i]);
        end
      end
      k = {1'b0, rif.len};
      // Trailing checksum mirrors what the host was asked to send
      if (rif.chk_en)
      begin
        n.q[k[2:0]]          = nib2hex(sum[7:4]);
        n.q[3'(k + 4'h1)]    = nib2hex(sum[3:0]);
        k                    = 4'(k + 4'h2);
      end
      n.q[k[2:0]] = `CH_CR;
      n.cnt       = 4'(k + 4'h1);
      n.idx       = 3'h0;
    end
    else if (rif.pop && r.cnt != 4'h0)
    begin
      n.idx = 3'(r.idx + 3'h1);
      n.cnt = 4'(r.cnt - 4'h1);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= '0;
    else
      r <= n;
  end
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic        init_sw_pos = 1'h0;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, cal_reload, active_protocol;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cal_n = 0;
  always #5 aclk = ~aclk;
  always @(posedge aclk) if (cal_reload === 1'h1) cal_n <= cal_n + 1;
  protocol_watchdog_cmd_interp #(.TENTH_CYCLES(4)) protocol_watchdog_cmd_interp_inst
  (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .init_sw_pos(init_sw_pos), .cal_reload(cal_reload), .active_protocol(active_protocol)
  );
  host_model host_model_inst
  (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Expected text without the closing carriage return; zero means no answer at all
  task automatic cmd(input string s, input logic [55:0] e);
    logic [63:0] g;
    host_model_inst.frame(s, g);
    check(s, g, (e == 56'h0) ? 64'h0 : {e, 8'h0D});
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Whole run is about 3700 cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    end_of_test;
  end
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    cmd("$01P", "!0110");
    cmd("$02P", 56'h0);
    cmd("$0GP", 56'h0);
    cmd("$01Q", "?01");
    cmd("$01P1", "?01");
    init_sw_pos <= 1'h1;
    cmd("$01P1", "!01");
    cmd("$01P", "!0111");
    check("active_protocol", active_protocol, 64'h0);
    cmd("$01P0", "!01");
    cmd("$01P", "!0110");
    $display("test protocol done");
    cmd("$01S0", "?01");
    cmd("$01S1", "!01");
    check("cal_reload pulses", 64'(cal_n), 64'h1);
    $display("test calibration done");
    cmd("~**", 56'h0);
    cmd("~010", "!0100");
    cmd("~0131FF", "!01");
    cmd("~010", "!0180");
    repeat (3)
    begin
      repeat (500) @(posedge aclk);
      cmd("~**", 56'h0);
    end
    cmd("~010", "!0180");
    repeat (1100) @(posedge aclk);
    cmd("~010", "!0104");
    cmd("~**", 56'h0);
    cmd("~010", "!0104");
    cmd("~011", "!01");
    cmd("~010", "!0100");
    host_model_inst.wr(8'h0C, 32'h0000FF04, r);
    check("nv write response", {62'h0, r}, 64'h0);
    cmd("~010", "!0104");
    host_model_inst.wr(8'h0C, 32'h0000FF00, r);
    host_model_inst.rd(8'h0C, d, r);
    check("nv readback", {32'h0, d}, 64'hFF04);
    cmd("~011", "!01");
    $display("test watchdog done");
    host_model_inst.rd(8'h10, d, r);
    check("status register", {32'h0, d}, 64'h0104);
    host_model_inst.wr(8'h08, 32'h0000032A, r);
    host_model_inst.rd(8'h08, d, r);
    check("config readback", {32'h0, d}, 64'h032A);
    cmd("$2APE7", "!2A10F5");
    cmd("$2APE6", 56'h0);
    cmd("$01PD5", 56'h0);
    host_model_inst.wr(8'h20, 32'h0, r);
    check("unmapped write response", {62'h0, r}, 64'h2);
    host_model_inst.rd(8'h20, d, r);
    check("unmapped read response", {62'h0, r}, 64'h2);
    $display("test register map done");
    end_of_test;
  end
endmodule
`default_nettype wire
